//--- core/reg_channel_defines.vh
`ifndef REG_CHANNEL_DEFINES_VH
`define REG_CHANNEL_DEFINES_VH

// ----------------------------------------
// Control and status byte layout
// ----------------------------------------
`define CTL_REG_MODE_BIT 7
`define CTL_WRITE_BIT 6
`define CTL_ADDR_MSB 5
`define CTL_ADDR_LSB 0
`define ADDR_W 6

// ----------------------------------------
// Register numbers and values
// ----------------------------------------
`define REG_CODE_WORD 6'h1f
`define REG_FEATURE 6'h20
`define REG_USER_FIRST 6'h1f
`define REG_USER_LAST 6'h2f
`define REG_MFR_FIRST 6'h10
`define UNLOCK_VALUE 16'h1235
`define ZERO_WORD 16'h0000
`define FEATURE_RESET 16'h0100

`endif

//--- core/param_store.v
`timescale 1ns/1ps
`default_nettype none

// Stored parameter word with a separate active copy that only a restart loads.
module param_store #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] DEFAULT = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Write port
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    // Values
    output reg [WIDTH-1:0] stored,
    output reg [WIDTH-1:0] active
);

    // The stored word survives the synchronous reset, as nonvolatile storage
    // would survive a power cycle; reset only reloads the active copy.
    reg loaded = 1'b0;

    always @(posedge clk) begin
        if (!loaded) begin
            stored <= DEFAULT;
            loaded <= 1'b1;
        end else if (wr_en) begin
            stored <= wr_data;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            active <= loaded ? stored : DEFAULT;
        end
    end

endmodule

`default_nettype wire

//--- core/reg_channel.v
// Functional notes
// RULE1: user registers read-only except code word
// RULE2: writing 0x1235 to register 31 unlocks
// RULE3: any other code value relocks
// RULE4: new values take effect only after restart
// RULE5: control bit 7 selects register mode
// RULE6: bit 6 one writes, zero reads
// RULE7: bits 5..0 hold register number
// RULE8: data word high byte first, then low
// RULE9: write receipt is control with bit6 cleared
// RULE10: read receipt echoes control byte
// RULE11: host ignores data word after writes
// RULE12: code word read returns current value
// RULE13: feature register read returns stored value
// RULE14: host relocks by writing zero word
// RULE15: host unlocks, verifies, then writes
// RULE16: locked code word reads as zero
// RULE17: bit 7 clear means process data
// RULE18: host holds request until receipt matches
`timescale 1ns/1ps
`default_nettype none
`include "reg_channel_defines.vh"

module reg_channel #(
    parameter WORD_W = 16,
    parameter NUM_REGS = 64
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Output channel from the host
    input wire [7:0] control_byte,
    input wire [7:0] host_out_hi,
    input wire [7:0] host_out_lo,
    // Input channel to the host
    output reg [7:0] status_byte,
    output reg [7:0] term_in_hi,
    output reg [7:0] term_in_lo,
    // Process data path
    input wire [7:0] proc_status,
    input wire [WORD_W-1:0] proc_in_word,
    output reg [7:0] proc_control,
    output reg [WORD_W-1:0] proc_out_word,
    // Active configuration and state
    output wire [WORD_W-1:0] feature_active,
    output reg write_enabled
);

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    wire reg_mode = control_byte[`CTL_REG_MODE_BIT]; // RULE5 RULE17
    wire is_write = control_byte[`CTL_WRITE_BIT]; // RULE6
    wire [`ADDR_W-1:0] addr = control_byte[`CTL_ADDR_MSB:`CTL_ADDR_LSB]; // RULE7
    wire [WORD_W-1:0] host_word = {host_out_hi, host_out_lo}; // RULE8

    // Fresh request: the control byte changed or register mode was entered.
    // A write is taken only on a fresh request, so a host that holds its
    // request until the receipt arrives does not rewrite the register each
    // cycle; to repeat a write it passes through another control byte first.
    reg [7:0] last_control;
    reg last_valid;
    wire fresh = !last_valid || (control_byte != last_control);

    // ----------------------------------------
    // Register areas
    // ----------------------------------------
    // Registers below the parameter area are fixed and never written.
    localparam [1:0] AREA_FIXED = 2'b00;
    localparam [1:0] AREA_PARAM = 2'b01;
    localparam [1:0] AREA_CODE = 2'b10;
    localparam [1:0] AREA_FEATURE = 2'b11;

    // Sorts a register number into the area that sets its access rights.
    function [1:0] area_of;
        input [`ADDR_W-1:0] a;
        begin
            if (a == `REG_CODE_WORD) begin
                area_of = AREA_CODE;
            end else if (a == `REG_FEATURE) begin
                area_of = AREA_FEATURE;
            end else if (a >= `REG_MFR_FIRST) begin
                area_of = AREA_PARAM;
            end else begin
                area_of = AREA_FIXED;
            end
        end
    endfunction

    // The code word is always writable; parameter areas only when unlocked.
    function is_writable;
        input [`ADDR_W-1:0] a;
        input unlocked;
        begin
            is_writable = (area_of(a) == AREA_CODE) ||
                          (unlocked && area_of(a) != AREA_FIXED);
        end
    endfunction

    wire do_write = reg_mode && is_write && fresh;
    wire wr_ok = do_write && is_writable(addr, write_enabled); // RULE1
    wire [1:0] area = area_of(addr);
    wire code_wr = wr_ok && (area == AREA_CODE);
    wire feature_wr = wr_ok && (area == AREA_FEATURE);
    wire param_wr = wr_ok && (area == AREA_PARAM);

    // ----------------------------------------
    // Code word and parameter storage
    // ----------------------------------------
    reg [WORD_W-1:0] code_word;
    reg [WORD_W-1:0] user_regs [0:NUM_REGS-1];
    // Marks words written since power-up; unwritten words read as zero.
    reg [NUM_REGS-1:0] param_written = {NUM_REGS{1'b0}};
    wire [WORD_W-1:0] feature_stored;

    always @(posedge clk) begin
        if (reset) begin
            code_word <= `ZERO_WORD;
            write_enabled <= 1'b0;
        end else if (code_wr) begin
            code_word <= host_word;
            write_enabled <= (host_word == `UNLOCK_VALUE); // RULE2 RULE3
        end
    end

    // Other writable parameter words; the stored copy only, so they survive
    // the synchronous reset that stands in for a restart.
    always @(posedge clk) begin
        if (param_wr) begin
            user_regs[addr] <= host_word; // RULE4
            param_written[addr] <= 1'b1;
        end
    end

    param_store #(
        .WIDTH(WORD_W),
        .DEFAULT(`FEATURE_RESET)
    ) u_feature (
        .clk(clk),
        .reset(reset),
        .wr_en(feature_wr),
        .wr_data(host_word),
        .stored(feature_stored),
        .active(feature_active) // RULE4
    );

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    // Fixed and reserved low registers read as zero.
    reg [WORD_W-1:0] read_word;
    always @* begin
        read_word = `ZERO_WORD;
        case (area)
            AREA_CODE: begin
                read_word = write_enabled ? code_word : `ZERO_WORD; // RULE12 RULE16
            end
            AREA_FEATURE: begin
                read_word = feature_stored; // RULE13
            end
            AREA_PARAM: begin
                read_word = param_written[addr] ? user_regs[addr] : `ZERO_WORD;
            end
            default: begin
                read_word = `ZERO_WORD;
            end
        endcase
    end

    // ----------------------------------------
    // Answer channel
    // ----------------------------------------
    reg [7:0] next_status;
    reg [WORD_W-1:0] next_in_word;
    reg [7:0] next_proc_control;
    reg [WORD_W-1:0] next_proc_word;

    // Process mode passes the counter data through in both directions.
    always @* begin
        next_status = status_byte;
        next_in_word = {term_in_hi, term_in_lo};
        next_proc_control = proc_control;
        next_proc_word = proc_out_word;
        if (reg_mode) begin
            if (is_write) begin
                next_status = control_byte & ~(8'h01 << `CTL_WRITE_BIT); // RULE9
                // The data word keeps its previous value after a write; the host discards it.
            end else begin
                next_status = control_byte; // RULE10
                next_in_word = read_word; // RULE12 RULE13
            end
        end else begin
            next_status = proc_status;
            next_in_word = proc_in_word;
            next_proc_control = control_byte; // RULE17
            next_proc_word = host_word;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            status_byte <= 8'h00;
            term_in_hi <= 8'h00;
            term_in_lo <= 8'h00;
            proc_control <= 8'h00;
            proc_out_word <= `ZERO_WORD;
            last_control <= 8'h00;
            last_valid <= 1'b0;
        end else begin
            status_byte <= next_status;
            term_in_hi <= next_in_word[15:8]; // RULE8
            term_in_lo <= next_in_word[7:0];
            proc_control <= next_proc_control;
            proc_out_word <= next_proc_word;
            last_control <= control_byte;
            last_valid <= reg_mode;
        end
    end

endmodule

`default_nettype wire

//--- bench/reg_channel_props.sv
`timescale 1ns/1ps
`default_nettype none
module reg_channel_props (
    // Clock
    input wire clk,
    input wire reset,
    // Host side
    input wire [7:0] control_byte,
    input wire [7:0] host_out_hi,
    input wire [7:0] host_out_lo,
    input wire [7:0] status_byte,
    input wire [7:0] term_in_hi,
    input wire [7:0] term_in_lo,
    // State
    input wire [7:0] proc_control,
    input wire [15:0] proc_out_word,
    input wire [15:0] feature_active,
    input wire write_enabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire [15:0] word = {host_out_hi, host_out_lo};
    wire [15:0] back = {term_in_hi, term_in_lo};
    wire code_wr = control_byte == 8'hdf;
    sequence s_unlock;
        $changed(control_byte) && code_wr && word == 16'h1235;
    endsequence
    a_write_receipt: assert property (
        control_byte[7:6] == 2'b11 |=> status_byte == ($past(control_byte) & 8'hbf))
        else $error("write receipt wrong");
    a_read_receipt: assert property (
        control_byte[7:6] == 2'b10 |=> status_byte == $past(control_byte))
        else $error("read receipt wrong");
    a_unlock_write: assert property (s_unlock |=> write_enabled)
        else $error("unlock missed");
    a_relock_write: assert property (
        $changed(control_byte) && code_wr && word != 16'h1235 |=> !write_enabled)
        else $error("relock missed");
    sequence s_code_read;
        control_byte == 8'h9f && write_enabled;
    endsequence
    a_code_readback: assert property (s_code_read |=> back == 16'h1235)
        else $error("code word readback wrong");
    a_locked_zero: assert property (
        control_byte == 8'h9f && !write_enabled |=> back == 16'h0000)
        else $error("locked code word not zero");
    a_feature_hold: assert property (!reset |=> $stable(feature_active))
        else $error("feature changed without restart");
    a_process_copy: assert property (
        !control_byte[7] |=> proc_control == $past(control_byte)
        && proc_out_word == $past(word)) else $error("process copy wrong");
endmodule
bind reg_channel reg_channel_props props (.clk(clk), .reset(reset),
    .control_byte(control_byte), .host_out_hi(host_out_hi), .host_out_lo(host_out_lo),
    .status_byte(status_byte), .term_in_hi(term_in_hi), .term_in_lo(term_in_lo),
    .proc_control(proc_control), .proc_out_word(proc_out_word),
    .feature_active(feature_active), .write_enabled(write_enabled));
`default_nettype wire

//--- bench/host_relay.sv
`timescale 1ns/1ps
`default_nettype none
module host_relay (
    // Clock and request
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] ctl,
    input wire logic [15:0] word,
    // Channel
    input wire logic [7:0] status_byte,
    output logic [7:0] control_byte,
    output logic [7:0] host_out_hi,
    output logic [7:0] host_out_lo,
    output wire logic done
);
    initial {control_byte, host_out_hi, host_out_lo} = 24'h000000;
    // A read carries no data, so the word is scrambled to expose any use of it.
    always @(posedge clk) if (go) begin
        control_byte <= #1 ctl;
        {host_out_hi, host_out_lo} <= #1 (ctl[7] && !ctl[6]) ?
            ~{host_out_hi, host_out_lo} : word;
    end
    // Only the receipt is trusted; the returned word is not used here.
    assign done = status_byte === (control_byte & 8'hbf);
endmodule
`default_nettype wire

//--- bench/reg_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module reg_channel_tb_top;
    logic clk = 0;
    logic reset = 1;
    logic go = 0;
    logic [7:0] ctl = 0;
    logic [15:0] word = 0;
    logic [7:0] p_status = 8'h00;
    logic [15:0] p_word = 16'h0000;
    wire [7:0] control_byte, host_out_hi, host_out_lo, status_byte, term_in_hi, term_in_lo;
    wire [7:0] proc_control;
    wire [15:0] proc_out_word, feature_active;
    wire write_enabled, done;
    int n_fail = 0;
    int samples_checked = 0;
    // Control, data word, expected receipt, expected read word.
    logic [47:0] rows [22] = '{48'h9f_0000_9f_0000, 48'he0_0002_a0_0000,
        48'ha0_0000_a0_0100, 48'hdf_1235_9f_0000, 48'h9f_0000_9f_1235,
        48'he0_0002_a0_0000, 48'ha0_0000_a0_0002, 48'he1_abcd_a1_0000,
        48'ha1_0000_a1_abcd, 48'hca_5555_8a_0000, 48'h8a_0000_8a_0000,
        48'hdf_0000_9f_0000, 48'h9f_0000_9f_0000, 48'he1_1111_a1_0000,
        48'ha1_0000_a1_abcd, 48'hdf_1235_9f_0000, 48'h9f_0000_9f_1235,
        48'hdf_1236_9f_0000, 48'h9f_0000_9f_0000, 48'he0_0007_a0_0000,
        48'ha0_0000_a0_0002, 48'ha2_0000_a2_0000};
    always #5 clk = ~clk;
    reg_channel dut (.clk(clk), .reset(reset), .control_byte(control_byte),
        .host_out_hi(host_out_hi), .host_out_lo(host_out_lo), .status_byte(status_byte),
        .term_in_hi(term_in_hi), .term_in_lo(term_in_lo), .proc_status(p_status),
        .proc_in_word(p_word), .proc_control(proc_control), .proc_out_word(proc_out_word),
        .feature_active(feature_active), .write_enabled(write_enabled));
    host_relay partner (.clk(clk), .go(go), .ctl(ctl), .word(word),
        .status_byte(status_byte), .control_byte(control_byte), .host_out_hi(host_out_hi),
        .host_out_lo(host_out_lo), .done(done));
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task send(input logic [7:0] c, input logic [15:0] w);
        int i;
        @(posedge clk) #1 go = 1;
        ctl = c;
        word = w;
        @(posedge clk) #1 go = 0;
        @(posedge clk) #1;
        for (i = 0; c[7] && i < 20 && done !== 1'b1; i++) @(posedge clk) #1;
        if (c[7] && done !== 1'b1) begin
            n_fail++;
            give_verdict;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 reset = 0;
        check({8'h00, status_byte}, 16'h0000, "status");
        // Unlock, verify, write, then relock, as the host sequence requires.
        foreach (rows[r]) begin
            send(rows[r][47:40], rows[r][39:24]);
            check({8'h00, status_byte}, rows[r][23:16], "status");
            if (!rows[r][46]) check({term_in_hi, term_in_lo}, rows[r][15:0], "word");
        end
        send(8'hdf, 16'h1235);
        check({15'h0000, write_enabled}, 16'h0001, "unlocked before restart");
        p_status = 8'h3c;
        p_word = 16'h5a5a;
        send(8'h05, 16'habcd);
        check(proc_out_word, 16'habcd, "process word");
        check({8'h00, proc_control}, 16'h0005, "process control");
        check({8'h00, status_byte}, 16'h003c, "process status");
        check({term_in_hi, term_in_lo}, 16'h5a5a, "process input word");
        check(feature_active, 16'h0100, "feature before restart");
        @(posedge clk) #1 reset = 1;
        @(posedge clk) #1 reset = 0;
        check(feature_active, 16'h0002, "feature after restart");
        check({15'h0000, write_enabled}, 16'h0000, "lock after restart");
        send(8'h9f, 16'h0000);
        check({term_in_hi, term_in_lo}, 16'h0000, "code word after restart");
        give_verdict;
    end
endmodule
`default_nettype wire
